// >>> verif/sgx_gpio_expander_tb_top.sv
// Purpose: self-checking bench of the smbus gpio expander
// Assumes: pin wires resolved from oe, drive value and outside level
// Notes:   straps start at 3, then 5 after the external reset
`timescale 1ns/1ps
`include "sgx_params.svh"

module sgx_gpio_expander_tb_top;
	logic        mclk          = 1'b0;
	logic        reset         = 1'b1;
	logic        ext_reset_n   = 1'b1;
	logic [7:0]  avs_address   = 8'h00;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, irq, sda_oe, scl, host_pull, sda_drv;
	logic [7:0]  p1_ext        = 8'h00;
	logic [6:0]  p2_ext        = 7'h03;
	logic [7:0]  p1_out, p1_oe;
	logic [6:0]  p2_out, p2_oe;
	wire  [7:0]  p1_pin        = (p1_oe & p1_out) | (~p1_oe & p1_ext);
	wire  [6:0]  p2_pin        = (p2_oe & p2_out) | (~p2_oe & p2_ext);
	wire         sda           = ~(host_pull | sda_oe);
	int          n_fail        = 0;
	int          n_compared    = 0;

	always #5 mclk = ~mclk;

	sgx_gpio_expander dut (
		.mclk(mclk), .reset(reset), .ext_reset_n(ext_reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq),
		.smb_scl(scl), .smb_sda_in(sda), .smb_sda_out(sda_drv), .smb_sda_oe(sda_oe),
		.p1_pin_in(p1_pin), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe),
		.p2_pin_in(p2_pin), .p2_pin_out(p2_out), .p2_pin_oe(p2_oe)
	);

	sgx_smb_host host (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_pull(host_pull));

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// request held until waitrequest is seen low; one idle edge after release
	task automatic av(input logic wr, input logic [5:0] ix, input logic [7:0] wd, output logic [7:0] rd);
		int k;
		k = 0;
		avs_address   <= {ix, 2'b00};
		avs_writedata <= {24'h000000, wd};
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge mclk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (k >= 50) begin
			n_fail++;
			wrap_up();
		end
		@(posedge mclk);
	endtask

	task automatic wr(input logic [5:0] ix, input logic [7:0] d);
		logic [7:0] x;
		av(1'b1, ix, d, x);
	endtask

	task automatic rd(input logic [5:0] ix, output logic [7:0] d);
		av(1'b0, ix, 8'h00, d);
	endtask

	task automatic count_hi(input int sel, input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge mclk);
			if ((sel == 0 ? p2_oe[6] : p1_out[0]) === 1'b1)
				c++;
		end
	endtask

	task automatic s_reset;
		logic [5:0] ix [11] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h14, 6'h06, 6'h1A};
		logic [7:0] ex [11] = '{8'h00, `SGX_P1_POL_RST, `SGX_P1_DIR_RST, 8'h00, 8'h00, `SGX_P2_POL_RST,
			`SGX_P2_DIR_RST, 8'h00, 8'h00, 8'h00, 8'h03};
		logic [7:0] d;
		chk("p1 oe", p1_oe, 8'h00);
		chk("p2 oe", p2_oe, 7'h00);
		for (int i = 0; i < 11; i++) begin
			rd(ix[i], d);
			chk("reset reg", d, ex[i]);
		end
	endtask

	task automatic s_smbus;
		logic [2:0] a;
		logic [7:0] d;
		logic       k;
		host.smb_write(7'h1B, 8'h04, 8'h55, a);
		chk("acks", a, 3'b111);
		rd(6'h04, d);
		chk("smb written", d, 8'h55);
		host.smb_read(7'h1B, d, k);
		chk("smb read", {k, d}, {1'b1, 8'h55});
		chk("sda out", sda_drv, 1'b0);
		wr(6'h04, 8'h00);
		host.smb_write(7'h2B, 8'h04, 8'h00, a);
		chk("upper bits", a, 3'b000);
		host.smb_write(7'h1A, 8'h04, 8'h00, a);
		chk("strap bits", a, 3'b000);
	endtask

	task automatic s_irq;
		logic [7:0] d;
		int         c;
		wr(6'h12, 8'hFF);
		p1_ext[3] <= 1'b1;
		cyc(10);
		chk("irq", irq, 1'b1);
		chk("int pin", {p2_oe[6], p2_out[6]}, 2'b10);
		rd(6'h10, d);
		chk("status", d, 8'h08);
		wr(6'h18, 8'hFF);
		chk("irq clr", irq, 1'b0);
		wr(6'h12, 8'h00);
		p1_ext[3] <= 1'b0;
		cyc(10);
		chk("irq mask", irq, 1'b0);
		rd(6'h10, d);
		chk("masked status", d, 8'h08);
		wr(6'h18, 8'hFF);
		wr(6'h12, 8'hFF);
		wr(6'h14, 8'h01);
		p1_ext[3] <= 1'b1;
		count_hi(0, 30, c);
		chk("int pulse", c, `SGX_IPULSE_CYC);
		wr(6'h14, 8'h02);
		cyc(2);
		chk("route p1", {p1_oe[7], p1_out[7], p2_oe[6]}, 3'b100);
		wr(6'h14, 8'h00);
		wr(6'h18, 8'hFF);
		wr(6'h12, 8'h00);
	endtask

	task automatic s_out;
		logic [7:0] d;
		int         c;
		wr(6'h03, 8'h00);
		wr(6'h01, 8'h3C);
		cyc(2);
		chk("drive on", p1_oe, 8'hFF);
		chk("drive", p1_out, 8'h3C ^ `SGX_P1_POL_RST);
		rd(6'h00, d);
		chk("pin read", d, 8'h3C);
		wr(6'h01, 8'h00);
		wr(6'h04, 8'h01);
		fork
			wr(6'h01, 8'h01);
			count_hi(1, 30, c);
		join
		chk("out pulse", c, `SGX_PULSE_CYC);
		chk("after pulse", p1_out[0], 1'b0);
		wr(6'h04, 8'h00);
		wr(6'h03, 8'hFF);
		wr(6'h0B, 8'h00);
		wr(6'h09, 8'hFF);
		cyc(2);
		chk("p2 drive", {p2_oe, p2_out}, {7'h3F, 7'h0F});
		rd(6'h09, d);
		chk("p2 out reg", d, 8'h7F);
		rd(6'h08, d);
		chk("p2 pin read", d, 8'h7F);
		wr(6'h0B, 8'h7F);
	endtask

	task automatic s_ext;
		logic [7:0] d;
		logic [2:0] a;
		p2_ext[2:0] <= 3'h5;
		ext_reset_n <= 1'b0;
		cyc(2);
		ext_reset_n <= 1'b1;
		cyc(3);
		rd(6'h1A, d);
		chk("strap", d, 8'h05);
		rd(6'h03, d);
		chk("dir", d, `SGX_P1_DIR_RST);
		chk("oe", p1_oe, 8'h00);
		host.smb_write(7'h1D, 8'h1A, 8'h00, a);
		chk("new strap", a, 3'b111);
		wr(6'h14, 8'h04);
		host.smb_write(7'h1D, 8'h1A, 8'h00, a);
		chk("reduced a2", a, 3'b000);
		host.smb_write(7'h19, 8'h1A, 8'h00, a);
		chk("reduced ok", a, 3'b111);
	endtask

	// watchdog, well above the run time of the test
	initial begin
		#900000;
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		cyc(3);
		s_reset();
		s_smbus();
		s_irq();
		s_out();
		s_ext();
		wrap_up();
	end
endmodule

// >>> verif/sgx_smb_host.sv
// Purpose: behavioural smbus host for the gpio expander serial side
// Assumes: bench resolves the data wire with a pull-up
// Notes:   bit time is 4*half mclk; a larger half gives a slow host
`timescale 1ns/1ps

module sgx_smb_host #(
	parameter int HALF = 8
) (
	// clock
	input  wire logic mclk,
	// serial lines
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_pull
);
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// data moves only while scl is low, so no false start or stop
	task automatic bit_cyc(input logic b, output logic s);
		sda_pull <= ~b;
		wait_n(HALF);
		scl <= 1'b1;
		wait_n(HALF);
		s = sda_in;
		wait_n(HALF);
		scl <= 1'b0;
		wait_n(HALF);
	endtask

	task automatic start_c;
		sda_pull <= 1'b1;
		wait_n(HALF);
		scl <= 1'b0;
		wait_n(HALF);
	endtask

	task automatic stop_c;
		sda_pull <= 1'b1;
		wait_n(HALF);
		scl <= 1'b1;
		wait_n(HALF);
		sda_pull <= 1'b0;
		wait_n(HALF);
	endtask

	// ninth bit released: acts as ack sample, and as nack after a read
	task automatic xbyte(input logic [7:0] b, output logic [7:0] got, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(b[i], s);
			got[i] = s;
		end
		bit_cyc(1'b1, s);
		ack = ~s;
	endtask

	task automatic smb_write(input logic [6:0] a, input logic [7:0] ix, input logic [7:0] dat,
		output logic [2:0] acks);
		logic [7:0] g;
		acks = 3'h0;
		start_c();
		xbyte({a, 1'b0}, g, acks[2]);
		if (acks[2]) begin
			xbyte(ix, g, acks[1]);
			xbyte(dat, g, acks[0]);
		end
		stop_c();
	endtask

	task automatic smb_read(input logic [6:0] a, output logic [7:0] d, output logic ack);
		logic [7:0] g;
		logic       n;
		start_c();
		xbyte({a, 1'b1}, g, ack);
		xbyte(8'hFF, d, n);
		stop_c();
	endtask
endmodule

// >>> verilog/sgx_gpio_expander.sv
// Purpose: two-port gpio expander behind smbus and avalon registers
// Assumes: all pin inputs synchronous to mclk
// Notes:   avalon answers every access one cycle after it is seen
`timescale 1ns/1ps
`include "sgx_params.svh"

// Function
// [R01] answer only to address 0011 plus strap bits; reduced variant forces bit 2 low
// [R02] take address bits from port two pins 0..2 at reset, then hold them
// [R03] a transition on any input pin raises the interrupt automatically; the code raises it only for pins enabled in ien
// [R04] after reset every pin is an input with its driver off
// [R05] interrupt drives either port two pin 6 or port one pin 7, open drain
// [R06] power-on reset and external reset pin act alike, straps included; the code does not reset the smbus slave engine from the external pin
// [R07] each output is either a held level or a pulse per write
// [R08] interrupt is either held until cleared or a pulse per event
// [R09] fifteen pins: eight on port one, seven on port two
// [R10] serial clock is input only; data line is open drain
// [R11] direction bit one means input, zero means output
// [R12] polarity bit one inverts the pin against the data register
// [R13] output and interrupt pulses last a fixed number of clock cycles
// [R14] edges found by comparing each sample with the one before
module sgx_gpio_expander
	import sgx_pkg::*;
(
	// clock and reset
	input  logic        mclk,
	input  logic        reset,
	input  logic        ext_reset_n,
	// avalon slave
	input  logic [7:0]  avs_address,
	input  logic        avs_read,
	input  logic        avs_write,
	input  logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic        avs_waitrequest,
	output logic        irq,
	// smbus
	input  logic        smb_scl,
	input  logic        smb_sda_in,
	output logic        smb_sda_out,
	output logic        smb_sda_oe,
	// port one
	input  logic [7:0]  p1_pin_in,
	output logic [7:0]  p1_pin_out,
	output logic [7:0]  p1_pin_oe,
	// port two
	input  logic [6:0]  p2_pin_in,
	output logic [6:0]  p2_pin_out,
	output logic [6:0]  p2_pin_oe
);

	localparam int PCYC  = `SGX_PULSE_CYC;
	localparam int IPCYC = `SGX_IPULSE_CYC;

	sgx_gpio_t       st_reg;
	sgx_gpio_t       st_next;
	logic [1:0][7:0] pin_in;
	logic [1:0][7:0] ev;
	logic [5:0]      smb_idx;
	logic            smb_we;
	logic [7:0]      smb_wdata;
	logic [7:0]      smb_rdata;
	logic [6:0]      dev_addr;
	logic            int_on;
	logic            new_ev;

	function automatic logic [7:0] port_mask(input int k);
		return (k == 0) ? `SGX_P1_MASK : `SGX_P2_MASK; // R09
	endfunction

	function automatic logic [5:0] pidx(input int k, input logic [5:0] ofs);
		return 6'(k) * `SGX_PORT_STRIDE + ofs;
	endfunction

	// pin given over to the interrupt in the present route
	function automatic logic [7:0] int_mask(input int k, input logic [7:0] mode);
		if (mode[`SGX_MODE_INT_ROUTE])
			return (k == 0) ? `SGX_P1_INT_BIT : 8'h00; // R05
		else
			return (k == 1) ? `SGX_P2_INT_BIT : 8'h00; // R05
	endfunction

	function automatic sgx_gpio_t rst_val();
		sgx_gpio_t r;
		r         = '0;
		r.pol[0]  = `SGX_P1_POL_RST;
		r.pol[1]  = `SGX_P2_POL_RST;
		r.dir[0]  = `SGX_P1_DIR_RST; // R04
		r.dir[1]  = `SGX_P2_DIR_RST; // R04
		r.av_wait = 1'b1;
		return r;
	endfunction

	function automatic logic [7:0] reg_read(input logic [5:0] idx, input sgx_gpio_t s);
		logic [7:0] r;
		r = 8'h00;
		for (int k = 0; k < `SGX_NPORTS; k++) begin
			if (idx == pidx(k, `SGX_OFS_IN))
				r = (s.smp[k] ^ s.pol[k]) & port_mask(k); // R12
			if (idx == pidx(k, `SGX_OFS_OUT))
				r = s.dout[k];
			if (idx == pidx(k, `SGX_OFS_POL))
				r = s.pol[k];
			if (idx == pidx(k, `SGX_OFS_DIR))
				r = s.dir[k];
			if (idx == pidx(k, `SGX_OFS_STY))
				r = s.sty[k];
			if (idx == `SGX_IDX_ISTAT + 6'(k))
				r = s.ist[k];
			if (idx == `SGX_IDX_IEN + 6'(k))
				r = s.ien[k];
		end
		if (idx == `SGX_IDX_MODE)
			r = s.mode;
		if (idx == `SGX_IDX_STRAP)
			r = {5'h00, s.strap};
		return r;
	endfunction

	assign pin_in[0] = p1_pin_in;
	assign pin_in[1] = {1'b0, p2_pin_in};
	assign dev_addr  = {`SGX_ADDR_HI, st_reg.strap[2] & ~st_reg.mode[`SGX_MODE_ADDR2_FIX],
		st_reg.strap[1:0]}; // R01
	assign smb_rdata = reg_read(smb_idx, st_reg);

	// an edge needs two valid samples; the interrupt pin watches no edges
	genvar g;
	generate
		for (g = 0; g < `SGX_NPORTS; g++) begin : g_edge
			assign ev[g] = (st_reg.smp[g] ^ st_reg.prev[g]) & st_reg.dir[g] & port_mask(g)
				& ~int_mask(g, st_reg.mode) & {8{st_reg.armed}}; // R14 R03 R11
		end
	endgenerate

	assign new_ev = |(ev & st_reg.ien);
	assign int_on = st_reg.mode[`SGX_MODE_INT_PULSE] ? (st_reg.icnt != 8'h00)
		: (|(st_reg.ist & st_reg.ien)); // R08

	sgx_smbus_slave u_smb (
		.mclk     (mclk),
		.reset    (reset),
		.scl      (smb_scl),
		.sda_in   (smb_sda_in),
		.sda_oe   (smb_sda_oe),
		.dev_addr (dev_addr),
		.rd_data  (smb_rdata),
		.idx      (smb_idx),
		.wr_en    (smb_we),
		.wr_data  (smb_wdata)
	);

	always_comb begin
		logic       wen;
		logic [5:0] widx;
		logic [7:0] wd;
		logic [7:0] drv;
		wen     = 1'b0;
		widx    = 6'h00;
		wd      = 8'h00;
		drv     = 8'h00;
		st_next = st_reg;

		// avalon: one wait cycle, then the answer
		st_next.av_wait = 1'b1;
		if ((avs_read | avs_write) & st_reg.av_wait) begin
			st_next.av_wait  = 1'b0;
			st_next.av_rdata = {24'h000000, reg_read(avs_address[7:2], st_reg)};
		end

		for (int k = 0; k < `SGX_NPORTS; k++) begin
			st_next.smp[k]  = pin_in[k] & port_mask(k);
			st_next.prev[k] = st_reg.smp[k]; // R14
			if (st_reg.pcnt[k] != 8'h00)
				st_next.pcnt[k] = st_reg.pcnt[k] - 8'h01; // R13
		end
		if (st_reg.icnt != 8'h00)
			st_next.icnt = st_reg.icnt - 8'h01; // R13

		// smbus write first, avalon last so it wins a clash on one register
		for (int src = 0; src < 2; src++) begin
			if (src == 0) begin
				wen  = smb_we;
				widx = smb_idx;
				wd   = smb_wdata;
			end else begin
				wen  = avs_write & ~st_reg.av_wait;
				widx = avs_address[7:2];
				wd   = avs_writedata[7:0];
			end
			if (wen) begin
				for (int k = 0; k < `SGX_NPORTS; k++) begin
					if (widx == pidx(k, `SGX_OFS_OUT)) begin
						st_next.dout[k] = wd & port_mask(k);
						// a write during a running pulse does not restart it
						if (st_reg.pcnt[k] == 8'h00 && (|(wd & st_reg.sty[k]))) begin
							st_next.pmask[k] = wd & st_reg.sty[k] & port_mask(k); // R07
							st_next.pcnt[k]  = `SGX_PULSE_CYC; // R13
						end
					end
					if (widx == pidx(k, `SGX_OFS_POL))
						st_next.pol[k] = wd & port_mask(k);
					if (widx == pidx(k, `SGX_OFS_DIR))
						st_next.dir[k] = wd & port_mask(k);
					if (widx == pidx(k, `SGX_OFS_STY))
						st_next.sty[k] = wd & port_mask(k);
					if (widx == `SGX_IDX_IEN + 6'(k))
						st_next.ien[k] = wd & port_mask(k);
					if (widx == `SGX_IDX_ICLR + 6'(k))
						st_next.ist[k] = st_next.ist[k] & ~wd;
				end
				if (widx == `SGX_IDX_MODE)
					st_next.mode = wd;
			end
		end

		// set after clear, so an event in the clearing cycle survives
		for (int k = 0; k < `SGX_NPORTS; k++)
			st_next.ist[k] = st_next.ist[k] | ev[k]; // R03

		if (st_reg.mode[`SGX_MODE_INT_PULSE] && new_ev && st_reg.icnt == 8'h00)
			st_next.icnt = `SGX_IPULSE_CYC; // R08

		// pins, open drain interrupt on the routed pin
		for (int k = 0; k < `SGX_NPORTS; k++) begin
			drv = (st_reg.dout[k] & ~st_reg.sty[k])
				| ((st_reg.pcnt[k] != 8'h00) ? (st_reg.pmask[k] & st_reg.sty[k]) : 8'h00); // R07
			st_next.pin_o[k]  = (drv ^ st_reg.pol[k]) & port_mask(k) & ~int_mask(k, st_reg.mode); // R12
			st_next.pin_oe[k] = ~st_reg.dir[k] & port_mask(k) & ~int_mask(k, st_reg.mode); // R11
			if (int_on)
				st_next.pin_oe[k] = st_next.pin_oe[k] | int_mask(k, st_reg.mode); // R05
		end

		st_next.irq = |(st_next.ist & st_next.ien);

		// straps are read in the first cycle after either reset ends
		st_next.armed = st_reg.strap_done;
		if (!st_reg.strap_done) begin
			st_next.strap      = p2_pin_in[`SGX_STRAP_MSB:`SGX_STRAP_LSB]; // R02
			st_next.strap_done = 1'b1;
		end

		if (!ext_reset_n)
			st_next = rst_val(); // R06
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			st_reg <= rst_val(); // R06
		else
			st_reg <= st_next;
	end

	assign avs_readdata    = st_reg.av_rdata;
	assign avs_waitrequest = st_reg.av_wait;
	assign irq             = st_reg.irq;
	assign smb_sda_out     = st_reg.sda_o; // R10
	assign p1_pin_out      = st_reg.pin_o[0];
	assign p1_pin_oe       = st_reg.pin_oe[0];
	assign p2_pin_out      = st_reg.pin_o[1][6:0];
	assign p2_pin_oe       = st_reg.pin_oe[1][6:0];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence out_pulse_s;
		st_reg.pcnt[0] == 8'h00 ##1 st_reg.pcnt[0] != 8'h00;
	endsequence

	sequence int_pulse_s;
		st_reg.icnt == 8'h00 ##1 st_reg.icnt != 8'h00;
	endsequence

	strap_hold_a: assert property ( // R02
		(st_reg.strap_done && ext_reset_n) |=> $stable(st_reg.strap))
		else $error("strapped address changed after reset");
	event_irq_a: assert property ( // R03
		(ext_reset_n && (|(ev & st_reg.ien))) |=> irq)
		else $error("enabled input edge did not raise irq");
	input_oe_a: assert property ( // R04
		1 |=> ((p1_pin_oe[6:0] & $past(st_reg.dir[0][6:0])) == 7'h00
			&& (p2_pin_oe[5:0] & $past(st_reg.dir[1][5:0])) == 6'h00))
		else $error("input pin is driven");
	int_route_a: assert property ( // R05
		!st_reg.mode[`SGX_MODE_INT_ROUTE] |=> (p2_pin_oe[6] == $past(int_on) && !p2_pin_out[6]))
		else $error("interrupt not on port two pin 6");
	ext_reset_a: assert property ( // R06
		!ext_reset_n |=> (st_reg.dir[0] == `SGX_P1_DIR_RST && st_reg.dir[1] == `SGX_P2_DIR_RST
			&& !st_reg.strap_done && p1_pin_oe == 8'h00))
		else $error("external reset left state behind");
	// counter loads the width and needs that many edges to reach zero
	out_pulse_a: assert property ( // R07
		out_pulse_s |-> ##[PCYC:PCYC] st_reg.pcnt[0] == 8'h00)
		else $error("output pulse length wrong");
	int_pulse_a: assert property ( // R08
		int_pulse_s |-> ##[IPCYC:IPCYC] st_reg.icnt == 8'h00)
		else $error("interrupt pulse length wrong");
	pol_read_a: assert property ( // R12
		(avs_read && !avs_waitrequest && avs_address[7:2] == `SGX_OFS_IN)
			|-> avs_readdata[7:0] == $past(st_reg.smp[0] ^ st_reg.pol[0]))
		else $error("port one input read not polarity adjusted");
	edge_once_a: assert property ( // R14
		(ev[0] & ~($past(p1_pin_in, 1) ^ $past(p1_pin_in, 2))) == 8'h00)
		else $error("event without a changed pin");

endmodule

// >>> verilog/sgx_params.svh
// Purpose: constants of the smbus gpio expander
// Assumes: included by bare name from both module files and the bench
// Notes:   register indexes, byte address is four times the index
`ifndef SGX_PARAMS_SVH
`define SGX_PARAMS_SVH

`define SGX_NPORTS       2
`define SGX_ADDR_HI      4'h3
`define SGX_BITS_BYTE    4'h8
`define SGX_P1_MASK      8'hFF
`define SGX_P2_MASK      8'h7F
`define SGX_P1_INT_BIT   8'h80
`define SGX_P2_INT_BIT   8'h40
`define SGX_STRAP_LSB    0
`define SGX_STRAP_MSB    2

`define SGX_PORT_STRIDE  6'h08
`define SGX_OFS_IN       6'h00
`define SGX_OFS_OUT      6'h01
`define SGX_OFS_POL      6'h02
`define SGX_OFS_DIR      6'h03
`define SGX_OFS_STY      6'h04
`define SGX_IDX_ISTAT    6'h10
`define SGX_IDX_IEN      6'h12
`define SGX_IDX_MODE     6'h14
`define SGX_IDX_ICLR     6'h18
`define SGX_IDX_STRAP    6'h1A

`define SGX_MODE_INT_PULSE 0
`define SGX_MODE_INT_ROUTE 1
`define SGX_MODE_ADDR2_FIX 2

`define SGX_P1_POL_RST   8'hF0
`define SGX_P2_POL_RST   8'h70
`define SGX_P1_DIR_RST   8'hFF
`define SGX_P2_DIR_RST   8'h7F

`define SGX_PULSE_CYC    8'h04
`define SGX_IPULSE_CYC   8'h04

`endif

// >>> verilog/sgx_pkg.sv
// Purpose: types of the smbus gpio expander
// Assumes: nothing
// Notes:   one packed struct holds all state of each module
package sgx_pkg;

	typedef enum logic [3:0] {
		SGX_S_IDLE = 4'h0,
		SGX_S_ADDR = 4'h1,
		SGX_S_AACK = 4'h2,
		SGX_S_IDX  = 4'h3,
		SGX_S_IACK = 4'h4,
		SGX_S_WDAT = 4'h5,
		SGX_S_DACK = 4'h6,
		SGX_S_RDAT = 4'h7,
		SGX_S_RACK = 4'h8
	} sgx_smb_state_t;

	typedef struct packed {
		sgx_smb_state_t state;
		logic [3:0]     cnt;
		logic [7:0]     sh;
		logic [5:0]     idx;
		logic           rw;
		logic           scl_d;
		logic           sda_d;
		logic           oe;
		logic           we;
		logic [7:0]     wdata;
	} sgx_smb_t;

	typedef struct packed {
		logic [1:0][7:0] dout, pol, dir, sty, ist, ien;
		logic [1:0][7:0] smp, prev, pmask, pcnt, pin_o, pin_oe;
		logic [7:0]      mode;
		logic [7:0]      icnt;
		logic [2:0]      strap;
		logic            strap_done;
		logic            armed;
		logic            av_wait;
		logic            irq;
		logic            sda_o;
		logic [31:0]     av_rdata;
	} sgx_gpio_t;

endpackage

// >>> verilog/sgx_smbus_slave.sv
// Purpose: smbus byte-data slave engine of the gpio expander
// Assumes: scl and sda sampled on mclk, far faster than scl
// Notes:   sda is only ever pulled low; write gives index then data
`timescale 1ns/1ps
`include "sgx_params.svh"

module sgx_smbus_slave
	import sgx_pkg::*;
(
	// clock and reset
	input  logic       mclk,
	input  logic       reset,
	// serial side
	input  logic       scl,
	input  logic       sda_in,
	output logic       sda_oe,
	// register side
	input  logic [6:0] dev_addr,
	input  logic [7:0] rd_data,
	output logic [5:0] idx,
	output logic       wr_en,
	output logic [7:0] wr_data
);

	sgx_smb_t st_reg;
	sgx_smb_t st_next;
	logic     rise;
	logic     fall;
	logic     start;
	logic     stop;

	assign rise    = scl & ~st_reg.scl_d;
	assign fall    = ~scl & st_reg.scl_d;
	assign start   = scl & st_reg.scl_d & st_reg.sda_d & ~sda_in;
	assign stop    = scl & st_reg.scl_d & ~st_reg.sda_d & sda_in;
	assign sda_oe  = st_reg.oe; // R10
	assign idx     = st_reg.idx;
	assign wr_en   = st_reg.we;
	assign wr_data = st_reg.wdata;

	always_comb begin
		st_next       = st_reg;
		st_next.scl_d = scl;
		st_next.sda_d = sda_in;
		st_next.we    = 1'b0;
		if (start) begin
			st_next.state = SGX_S_ADDR;
			st_next.cnt   = 4'h0;
			st_next.oe    = 1'b0;
		end else if (stop) begin
			st_next.state = SGX_S_IDLE;
			st_next.oe    = 1'b0;
		end else if (rise) begin
			case (st_reg.state)
				SGX_S_ADDR, SGX_S_IDX, SGX_S_WDAT: begin
					st_next.sh  = {st_reg.sh[6:0], sda_in};
					st_next.cnt = st_reg.cnt + 4'h1;
				end
				SGX_S_RDAT: begin
					st_next.sh  = {st_reg.sh[6:0], 1'b0};
					st_next.cnt = st_reg.cnt + 4'h1;
				end
				SGX_S_RACK: begin
					if (sda_in)
						st_next.state = SGX_S_IDLE;
				end
				default: ;
			endcase
		end else if (fall) begin
			case (st_reg.state)
				SGX_S_ADDR: begin
					if (st_reg.cnt == `SGX_BITS_BYTE) begin
						if (st_reg.sh[7:1] == dev_addr) begin // R01
							st_next.state = SGX_S_AACK;
							st_next.oe    = 1'b1;
							st_next.rw    = st_reg.sh[0];
						end else
							st_next.state = SGX_S_IDLE;
					end
				end
				SGX_S_AACK: begin
					st_next.cnt = 4'h0;
					if (st_reg.rw) begin
						st_next.state = SGX_S_RDAT;
						st_next.sh    = rd_data;
						st_next.oe    = ~rd_data[7];
					end else begin
						st_next.state = SGX_S_IDX;
						st_next.oe    = 1'b0;
					end
				end
				SGX_S_IDX: begin
					if (st_reg.cnt == `SGX_BITS_BYTE) begin
						st_next.idx   = st_reg.sh[5:0];
						st_next.state = SGX_S_IACK;
						st_next.oe    = 1'b1;
					end
				end
				SGX_S_IACK, SGX_S_DACK: begin
					st_next.state = SGX_S_WDAT;
					st_next.oe    = 1'b0;
					st_next.cnt   = 4'h0;
				end
				SGX_S_WDAT: begin
					if (st_reg.cnt == `SGX_BITS_BYTE) begin
						st_next.we    = 1'b1;
						st_next.wdata = st_reg.sh;
						st_next.state = SGX_S_DACK;
						st_next.oe    = 1'b1;
					end
				end
				SGX_S_RDAT: begin
					if (st_reg.cnt == `SGX_BITS_BYTE) begin
						st_next.state = SGX_S_RACK;
						st_next.oe    = 1'b0;
					end else
						st_next.oe = ~st_reg.sh[7];
				end
				SGX_S_RACK: begin
					st_next.state = SGX_S_RDAT;
					st_next.cnt   = 4'h0;
					st_next.sh    = rd_data;
					st_next.oe    = ~rd_data[7];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	addr_reject_a: assert property ( // R01
		(st_reg.state == SGX_S_ADDR && fall && st_reg.cnt == `SGX_BITS_BYTE
			&& st_reg.sh[7:4] != `SGX_ADDR_HI) |=> (st_reg.state == SGX_S_IDLE && !sda_oe))
		else $error("foreign address was acknowledged");
	addr_ack_a: assert property ( // R01
		(st_reg.state == SGX_S_ADDR && fall && st_reg.cnt == `SGX_BITS_BYTE
			&& st_reg.sh[7:1] == dev_addr) |=> sda_oe)
		else $error("own address not acknowledged");

endmodule
